//--- hdl/csb_dev.sv
// Device end: command issue, probe response, fills and lane masks
// Behaviour
// RULE_01: Top address bit set means noncached space
// RULE_02: Bits 38:37 carry byte/word transfer length
// RULE_03: System takes address and command lines
// RULE_04: Address response 00 nop, 01 miss, 11 supply
// RULE_05: System acknowledges every device command
// RULE_06: Device commands: nop, write, miss0/1, victim
// RULE_07: System commands: nop, flush, invalidate, read
// RULE_08: Data takeover sampled high stops next drive
// RULE_09: System idles cache before data takeover
// RULE_10: Fill warning presents slot address next edge
// RULE_11: No data ack repeats cache write later
// RULE_12: System flags dirty fill blocks
// RULE_13: System flags fault yet completes fill
// RULE_14: Each fill fault raises one machine check
// RULE_15: Slot select picks miss slot one or zero
// RULE_16: Idle input stalls new cache operations
// RULE_17: System idles cache before fill data
// RULE_18: Write lane mask marks 32-bit slices
// RULE_19: Read lane mask marks 64-bit quadwords
// RULE_20: Byte/word reads put low address on mask; LEN_8 reads here put REQ_MASK_I instead
// RULE_21: Byte/word writes: longword mask or address
// RULE_22: All signals change on rising clock edges
`timescale 1ns/10ps
module csb_dev (
    // Clock and reset
    input  wire logic         CLK_I,
    input  wire logic         RST_I,
    input  wire logic         CE_I,
    // Outgoing request
    input  wire logic         REQ_VALID_I,
    input  wire logic [2:0]   REQ_KIND_I,
    input  wire logic         REQ_SLOT_I,
    input  wire logic [35:0]  REQ_ADDR_I,
    input  wire logic [1:0]   REQ_LEN_I,
    input  wire logic [3:0]   REQ_LOW_ADDR_I,
    input  wire logic [3:0]   REQ_MASK_I,
    input  wire logic [127:0] REQ_DATA_I,
    output logic              REQ_READY_O,
    // Probe answer from the cache
    input  wire logic         PROBE_HIT_DIRTY_I,
    output logic              PROBE_VALID_O,
    output logic [3:0]        PROBE_CMD_O,
    output logic [35:0]       PROBE_ADDR_O,
    // Board cache side
    output logic              BC_WRITE_O,
    output logic [35:0]       BC_INDEX_O,
    output logic [127:0]      BC_WDATA_O,
    output logic              BC_FILL_DIRTY_O,
    // Status
    output logic              MACHINE_CHECK_TRAP_O,
    output logic [35:0]       MISS_SLOT0_O,
    output logic [35:0]       MISS_SLOT1_O,
    csb_if.dev                bus
);
    // ************************************************************
    // Command issue state machine
    // ************************************************************
    csb_pkg::csb_state_type state;
    logic [35:0] miss_slot0;
    logic [35:0] miss_slot1;
    logic        nc;
    logic [3:0]  next_cmd;
    logic [3:0]  next_mask;
    logic [35:0] next_addr;

    // Command code and lane mask for the request on offer
    always_comb begin
        nc        = REQ_ADDR_I[csb_pkg::NONCACHED_BIT - csb_pkg::ADDR_LSB];  // see RULE_01
        next_addr = REQ_ADDR_I;
        next_mask = 4'h0;
        case (REQ_KIND_I)
            csb_pkg::REQ_MISS:     next_cmd = REQ_SLOT_I ? csb_pkg::DCMD_MISS1
                                                         : csb_pkg::DCMD_MISS0;  // see RULE_06
            csb_pkg::REQ_VICTIM:   next_cmd = csb_pkg::DCMD_VICTIM;
            default:               next_cmd = nc ? (REQ_KIND_I == csb_pkg::REQ_WRBLK ||
                                                    REQ_KIND_I == csb_pkg::REQ_NC_WRITE ||
                                                    REQ_KIND_I == csb_pkg::REQ_BW_WRITE)
                                                   ? csb_pkg::DCMD_WRBLK : csb_pkg::DCMD_MISS0
                                                 : csb_pkg::DCMD_WRBLK;
        endcase
        if (REQ_KIND_I == csb_pkg::REQ_NC_WRITE || REQ_KIND_I == csb_pkg::REQ_NC_READ) begin
            next_mask = REQ_MASK_I;  // see RULE_18 see RULE_19
        end
        if (nc && (REQ_KIND_I == csb_pkg::REQ_BW_READ || REQ_KIND_I == csb_pkg::REQ_BW_WRITE)) begin
            // Length rides in two upper address lines
            next_addr[csb_pkg::SIZE_HI - csb_pkg::ADDR_LSB -: 2] = REQ_LEN_I;  // see RULE_02
            case (REQ_LEN_I)
                csb_pkg::LEN_8: next_mask = REQ_MASK_I;  // see RULE_20 see RULE_21
                csb_pkg::LEN_4: next_mask = (REQ_KIND_I == csb_pkg::REQ_BW_WRITE)
                                            ? REQ_MASK_I : {REQ_LOW_ADDR_I[3:2], 2'h0};
                csb_pkg::LEN_2: next_mask = {REQ_LOW_ADDR_I[3:1], 1'b0};
                default:        next_mask = REQ_LOW_ADDR_I;
            endcase
        end
    end

    // Command held on the lines until acknowledged
    always_ff @(posedge CLK_I) begin  // see RULE_22
        if (RST_I) begin
            state               <= csb_pkg::CSB_IDLE;
            bus.cmd_dev         <= csb_pkg::RST_CMD;
            bus.addr_dev        <= '0;
            bus.data_dev        <= '0;
            bus.lane_valid_mask <= 4'h0;
            miss_slot0          <= '0;
            miss_slot1          <= '0;
        end else if (CE_I) begin
            case (state)
                csb_pkg::CSB_IDLE: begin
                    if (bus.fill_warn) begin
                        state <= csb_pkg::CSB_FILL;
                    end else if (REQ_VALID_I && !bus.addr_bus_req && !bus.board_cache_idle) begin
                        state               <= csb_pkg::CSB_CMD;  // see RULE_16
                        bus.cmd_dev         <= next_cmd;
                        bus.addr_dev        <= next_addr;
                        bus.data_dev        <= REQ_DATA_I;
                        bus.lane_valid_mask <= next_mask;
                        if (REQ_KIND_I == csb_pkg::REQ_MISS && REQ_SLOT_I) begin
                            miss_slot1 <= REQ_ADDR_I;
                        end else if (REQ_KIND_I == csb_pkg::REQ_MISS) begin
                            miss_slot0 <= REQ_ADDR_I;
                        end
                    end
                end
                csb_pkg::CSB_CMD: begin
                    if (bus.cmd_ack) begin
                        state       <= csb_pkg::CSB_IDLE;  // see RULE_05
                        bus.cmd_dev <= csb_pkg::DCMD_NOP;
                    end
                end
                csb_pkg::CSB_FILL: begin
                    // Without data ack the cache write is done again
                    state <= bus.data_ack ? csb_pkg::CSB_IDLE : csb_pkg::CSB_FRPT;  // see RULE_11
                end
                csb_pkg::CSB_FRPT: begin
                    state <= csb_pkg::CSB_FILL;
                end
                default: state <= csb_pkg::CSB_IDLE;
            endcase
        end
    end
    // Lines released whenever the system holds the address bus
    assign bus.cmd_dev_oe  = state == csb_pkg::CSB_CMD && !bus.addr_bus_req;  // see RULE_03
    assign bus.addr_dev_oe = state == csb_pkg::CSB_CMD && !bus.addr_bus_req;
    assign REQ_READY_O     = state == csb_pkg::CSB_IDLE && !bus.fill_warn &&
                             !bus.addr_bus_req && !bus.board_cache_idle;
    assign MISS_SLOT0_O    = miss_slot0;
    assign MISS_SLOT1_O    = miss_slot1;

    // ************************************************************
    // Data bus drive follows the takeover input one edge later
    // ************************************************************
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            bus.data_dev_oe <= 1'b0;
        end else if (CE_I) begin
            bus.data_dev_oe <= !bus.data_bus_req;  // see RULE_08
        end
    end

    // ************************************************************
    // Fill write into the board cache
    // ************************************************************
    logic fill_slot;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            fill_slot       <= 1'b0;
            BC_WRITE_O      <= 1'b0;
            BC_INDEX_O      <= '0;
            BC_WDATA_O      <= '0;
            BC_FILL_DIRTY_O <= 1'b0;
        end else if (CE_I) begin
            BC_WRITE_O <= 1'b0;
            if (state == csb_pkg::CSB_IDLE && bus.fill_warn) begin
                fill_slot  <= bus.fill_slot_select;
                BC_WRITE_O <= 1'b1;  // see RULE_10
                BC_INDEX_O <= bus.fill_slot_select ? miss_slot1 : miss_slot0;  // see RULE_15
                BC_WDATA_O      <= bus.data;
                BC_FILL_DIRTY_O <= bus.fill_dirty;
            end else if (state == csb_pkg::CSB_FRPT) begin
                BC_WRITE_O <= 1'b1;  // see RULE_11
                BC_INDEX_O <= fill_slot ? miss_slot1 : miss_slot0;
                BC_WDATA_O <= bus.data;
            end
        end
    end

    // ************************************************************
    // Machine check: one pulse per rising fault assertion in a fill
    // ************************************************************
    logic fault_seen;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            fault_seen           <= 1'b0;
            MACHINE_CHECK_TRAP_O <= 1'b0;
        end else if (CE_I) begin
            fault_seen           <= bus.fill_fault &&
                                    state inside {csb_pkg::CSB_FILL, csb_pkg::CSB_FRPT};
            MACHINE_CHECK_TRAP_O <= bus.fill_fault && !fault_seen &&  // see RULE_14
                                    state inside {csb_pkg::CSB_FILL, csb_pkg::CSB_FRPT};
        end
    end

    // ************************************************************
    // Probe answer: dirty hit supplies data except on invalidate, else not found
    // ************************************************************
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            bus.addr_resp <= csb_pkg::RST_RESP;
            PROBE_VALID_O <= 1'b0;
            PROBE_CMD_O   <= csb_pkg::SCMD_NOP;
            PROBE_ADDR_O  <= '0;
        end else if (CE_I) begin
            PROBE_VALID_O <= 1'b0;
            bus.addr_resp <= csb_pkg::RESP_NOP;
            if (bus.addr_bus_req && bus.cmd != csb_pkg::SCMD_NOP) begin
                PROBE_VALID_O <= 1'b1;  // see RULE_07
                PROBE_CMD_O   <= bus.cmd;
                PROBE_ADDR_O  <= bus.addr;
                bus.addr_resp <= (PROBE_HIT_DIRTY_I && bus.cmd != csb_pkg::SCMD_INVAL)
                                 ? csb_pkg::RESP_BCACHE : csb_pkg::RESP_NOT_FOUND;  // see RULE_04
            end
        end
    end
endmodule : csb_dev

//--- hdl/csb_pkg.sv
// Package of constants shared by both ends of the system bus interface
package csb_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADDR_W = 36;   // address lines 39:4
    localparam int DATA_W = 128;
    localparam int CMD_W  = 4;

    // ************************************************************
    // Address field positions (absolute bit numbers, offset 4)
    // ************************************************************
    localparam int ADDR_LSB      = 4;
    localparam int NONCACHED_BIT = 39;
    localparam int SIZE_HI       = 38;
    localparam int SIZE_LO       = 37;

    // ************************************************************
    // Transfer lengths
    // ************************************************************
    localparam logic [1:0] LEN_8 = 2'h0;
    localparam logic [1:0] LEN_4 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_1 = 2'h3;

    // ************************************************************
    // Address response codes
    // ************************************************************
    localparam logic [1:0] RESP_NOP       = 2'h0;
    localparam logic [1:0] RESP_NOT_FOUND = 2'h1;
    localparam logic [1:0] RESP_BCACHE    = 2'h3;

    // ************************************************************
    // Device-to-system commands
    // ************************************************************
    localparam logic [3:0] DCMD_NOP    = 4'h0;
    localparam logic [3:0] DCMD_WRBLK  = 4'h6;
    localparam logic [3:0] DCMD_MISS0  = 4'h8;
    localparam logic [3:0] DCMD_MISS1  = 4'h9;
    localparam logic [3:0] DCMD_VICTIM = 4'hC;

    // ************************************************************
    // System-to-device commands
    // ************************************************************
    localparam logic [3:0] SCMD_NOP   = 4'h0;
    localparam logic [3:0] SCMD_FLUSH = 4'h1;
    localparam logic [3:0] SCMD_INVAL = 4'h2;
    localparam logic [3:0] SCMD_READ  = 4'h4;

    // ************************************************************
    // Request kinds on the device user side
    // ************************************************************
    localparam logic [2:0] REQ_MISS      = 3'h0;
    localparam logic [2:0] REQ_VICTIM    = 3'h1;
    localparam logic [2:0] REQ_WRBLK     = 3'h2;
    localparam logic [2:0] REQ_NC_READ   = 3'h3;
    localparam logic [2:0] REQ_NC_WRITE  = 3'h4;
    localparam logic [2:0] REQ_BW_READ   = 3'h5;
    localparam logic [2:0] REQ_BW_WRITE  = 3'h6;

    // ************************************************************
    // Device bus states
    // ************************************************************
    typedef enum logic [3:0] {
        CSB_IDLE = 4'b0001,
        CSB_CMD  = 4'b0010,
        CSB_FILL = 4'b0100,
        CSB_FRPT = 4'b1000
    } csb_state_type;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [3:0] RST_CMD  = 4'h0;
    localparam logic [1:0] RST_RESP = 2'h0;

endpackage : csb_pkg

//--- hdl/csb_if.sv
// Interface joining the device end and the system end of the bus
`timescale 1ns/10ps
interface csb_if;
    logic [35:0]  addr_dev;      // address driven by device
    logic         addr_dev_oe;
    logic [35:0]  addr_sys;      // address driven by system
    logic         addr_sys_oe;
    logic [3:0]   cmd_dev;
    logic         cmd_dev_oe;
    logic [3:0]   cmd_sys;
    logic         cmd_sys_oe;
    logic [127:0] data_dev;
    logic         data_dev_oe;
    logic [127:0] data_sys;
    logic         data_sys_oe;
    logic         addr_bus_req;
    logic [1:0]   addr_resp;
    logic         cmd_ack;
    logic         data_ack;
    logic         data_bus_req;
    logic         fill_warn;
    logic         fill_dirty;
    logic         fill_fault;
    logic         fill_slot_select;
    logic         board_cache_idle;
    logic [3:0]   lane_valid_mask;

    // Resolved shared lines, the system wins; undriven address and data lines read inverted, undriven cmd reads zero
    logic [35:0]  addr;
    logic [3:0]   cmd;
    logic [127:0] data;
    assign addr = addr_sys_oe ? addr_sys : (addr_dev_oe ? addr_dev : ~addr_dev);
    assign cmd  = cmd_sys_oe ? cmd_sys : (cmd_dev_oe ? cmd_dev : 4'h0);
    assign data = data_sys_oe ? data_sys : (data_dev_oe ? data_dev : ~data_dev);

    modport dev (
        output addr_dev, addr_dev_oe, cmd_dev, cmd_dev_oe, data_dev, data_dev_oe,
               addr_resp, lane_valid_mask,
        input  addr, cmd, data, addr_bus_req, cmd_ack, data_ack, data_bus_req,
               fill_warn, fill_dirty, fill_fault, fill_slot_select, board_cache_idle
    );
    modport sys (
        output addr_sys, addr_sys_oe, cmd_sys, cmd_sys_oe, data_sys, data_sys_oe,
               addr_bus_req, cmd_ack, data_ack, data_bus_req, fill_warn, fill_dirty,
               fill_fault, fill_slot_select, board_cache_idle,
        input  addr, cmd, data, addr_resp, lane_valid_mask
    );
endinterface : csb_if

//--- hdl/csb_sys.sv
// System end: acknowledges commands, issues probes and runs fills
`timescale 1ns/10ps
module csb_sys (
    // Clock and reset
    input  wire logic         CLK_I,
    input  wire logic         RST_I,
    input  wire logic         CE_I,
    // Probe command request
    input  wire logic         PROBE_REQ_I,
    input  wire logic [3:0]   PROBE_CMD_I,
    input  wire logic [35:0]  PROBE_ADDR_I,
    output logic              PROBE_BUSY_O,
    // Fill request
    input  wire logic         FILL_REQ_I,
    input  wire logic         FILL_SLOT_I,
    input  wire logic         FILL_DIRTY_I,
    input  wire logic         FILL_FAULT_I,
    input  wire logic [127:0] FILL_DATA_I,
    output logic              FILL_BUSY_O,
    // Observed device commands
    output logic              DEV_CMD_VALID_O,
    output logic [3:0]        DEV_CMD_O,
    output logic [35:0]       DEV_ADDR_O,
    output logic [1:0]        PROBE_RESP_O,
    csb_if.sys                bus
);
    // ************************************************************
    // Command acknowledge
    // ************************************************************
    logic cmd_seen;

    // Every device command is acknowledged one cycle after it appears
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cmd_seen        <= 1'b0;
            DEV_CMD_VALID_O <= 1'b0;
            DEV_CMD_O       <= csb_pkg::RST_CMD;
            DEV_ADDR_O      <= '0;
        end else if (CE_I) begin
            cmd_seen        <= !cmd_seen && !bus.addr_sys_oe && bus.cmd != csb_pkg::DCMD_NOP;
            DEV_CMD_VALID_O <= 1'b0;
            if (!cmd_seen && !bus.addr_sys_oe && bus.cmd != csb_pkg::DCMD_NOP) begin
                DEV_CMD_VALID_O <= 1'b1;
                DEV_CMD_O       <= bus.cmd;
                DEV_ADDR_O      <= bus.addr;
            end
        end
    end
    assign bus.cmd_ack = cmd_seen;  // see RULE_05

    // ************************************************************
    // Probe issue: take the address bus, drive one command
    // ************************************************************
    logic [1:0] probe_cnt;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            probe_cnt    <= 2'h0;
            bus.cmd_sys  <= csb_pkg::SCMD_NOP;
            bus.addr_sys <= '0;
            PROBE_RESP_O <= csb_pkg::RST_RESP;
        end else if (CE_I) begin
            if (probe_cnt == 2'h0 && PROBE_REQ_I) begin
                probe_cnt    <= 2'h1;
                bus.cmd_sys  <= PROBE_CMD_I;  // see RULE_07
                bus.addr_sys <= PROBE_ADDR_I;
            end else if (probe_cnt != 2'h0) begin
                probe_cnt <= probe_cnt + 2'h1;
                if (probe_cnt == 2'h2) begin
                    PROBE_RESP_O <= bus.addr_resp;
                end
            end
        end
    end
    assign bus.addr_bus_req = probe_cnt != 2'h0;  // see RULE_03
    assign bus.addr_sys_oe  = probe_cnt != 2'h0;
    assign bus.cmd_sys_oe   = probe_cnt == 2'h1;
    assign PROBE_BUSY_O     = probe_cnt != 2'h0;

    // ************************************************************
    // Fill: idle cache, take data bus, warn, then data with ack
    // ************************************************************
    logic [2:0] fill_step;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            fill_step        <= 3'h0;
            bus.data_sys     <= '0;
            bus.fill_slot_select <= 1'b0;
            bus.fill_dirty   <= 1'b0;
            bus.fill_fault   <= 1'b0;
        end else if (CE_I) begin
            if (fill_step == 3'h0 && FILL_REQ_I) begin
                fill_step            <= 3'h1;
                bus.fill_slot_select <= FILL_SLOT_I;
                bus.fill_dirty       <= FILL_DIRTY_I;  // see RULE_12
                bus.fill_fault       <= FILL_FAULT_I;  // see RULE_13
                bus.data_sys         <= FILL_DATA_I;
            end else if (fill_step != 3'h0) begin
                fill_step <= (fill_step == (bus.fill_dirty ? 3'h6 : 3'h5))
                             ? 3'h0 : fill_step + 3'h1;
            end
        end
    end
    assign bus.board_cache_idle = fill_step != 3'h0;          // see RULE_09 see RULE_17
    assign bus.data_bus_req     = fill_step >= 3'h2;
    assign bus.data_sys_oe      = fill_step >= 3'h3;
    assign bus.fill_warn        = fill_step == 3'h3;
    assign bus.data_ack         = fill_step == (bus.fill_dirty ? 3'h6 : 3'h4);  // Dirty: one repeat
    assign FILL_BUSY_O          = fill_step != 3'h0;
endmodule : csb_sys

//--- tb/csb_sva.sv
// Concurrent checks on the shared bus between both ends
`timescale 1ns/10ps
module csb_sva (
    // Clock and reset
    input wire logic       CLK_I,
    input wire logic       RST_I,
    // Watched bus signals
    input wire logic [3:0] cmd_dev,
    input wire logic       cmd_dev_oe,
    input wire logic       cmd_ack,
    input wire logic [3:0] cmd,
    input wire logic       addr_bus_req,
    input wire logic [1:0] addr_resp,
    input wire logic       data_bus_req,
    input wire logic       data_dev_oe,
    input wire logic       board_cache_idle
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // Steps of the command handshake
    sequence s_cmd_out; $rose(cmd_dev_oe); endsequence
    sequence s_cmd_wait; cmd_dev_oe && !cmd_ack; endsequence
    a_dcmd_legal: assert property (cmd_dev_oe |->
        cmd_dev inside {4'h0, 4'h6, 4'h8, 4'h9, 4'hC})
        else $error("reserved device command");
    a_cmd_acked: assert property (s_cmd_out |-> ##[1:4] cmd_ack)
        else $error("device command not acknowledged");
    a_cmd_held: assert property (s_cmd_wait |=> cmd_dev_oe && $stable(cmd_dev))
        else $error("command changed before acknowledge");
    a_cmd_drop: assert property (cmd_dev_oe && cmd_ack |=>
        !cmd_dev_oe || cmd_dev == 4'h0)
        else $error("command kept after acknowledge");
    a_resp_legal: assert property (addr_resp != 2'h2)
        else $error("reserved address response");
    a_inval_resp: assert property (addr_bus_req && cmd == 4'h2 |=> addr_resp != 2'h3)
        else $error("cache supply on invalidate");
    a_bus_off: assert property (data_bus_req |=> !data_dev_oe)
        else $error("data driven during takeover");
    a_bus_on: assert property (!data_bus_req && !RST_I |=> data_dev_oe)
        else $error("data not driven without takeover");
    a_idle_first: assert property ($rose(data_bus_req) |-> $past(board_cache_idle))
        else $error("takeover without idle cache");
endmodule : csb_sva

//--- tb/cpu_system_bus_interface_tb.sv
// Self-checking bench joining the device end and the system end
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module cpu_system_bus_interface_tb;
    logic CLK_I, RST_I, CE_I, REQ_VALID_I, REQ_SLOT_I, PROBE_HIT_DIRTY_I, PROBE_REQ_I;
    logic FILL_REQ_I, FILL_SLOT_I, FILL_DIRTY_I, FILL_FAULT_I, REQ_READY_O, PROBE_VALID_O;
    logic BC_WRITE_O, BC_FILL_DIRTY_O, MACHINE_CHECK_TRAP_O, PROBE_BUSY_O, FILL_BUSY_O;
    logic DEV_CMD_VALID_O;
    logic [2:0] REQ_KIND_I;
    logic [1:0] REQ_LEN_I, PROBE_RESP_O;
    logic [3:0] REQ_LOW_ADDR_I, REQ_MASK_I, PROBE_CMD_I, PROBE_CMD_O, DEV_CMD_O;
    logic [35:0] REQ_ADDR_I, PROBE_ADDR_I, PROBE_ADDR_O, BC_INDEX_O, MISS_SLOT0_O;
    logic [35:0] MISS_SLOT1_O, DEV_ADDR_O, slot_a [2];
    logic [127:0] REQ_DATA_I, FILL_DATA_I, BC_WDATA_O;
    int miscompares = 0, checks = 0, cyc = 0, seed = 32'h1e3b, w, n, t, i;
    csb_if bus ();
    csb_dev u_csb_dev (.*);
    csb_sys u_csb_sys (.*);
    csb_sva u_csb_sva (.CLK_I(CLK_I), .RST_I(RST_I), .cmd_dev(bus.cmd_dev),
        .cmd_dev_oe(bus.cmd_dev_oe), .cmd_ack(bus.cmd_ack), .cmd(bus.cmd),
        .addr_bus_req(bus.addr_bus_req), .addr_resp(bus.addr_resp),
        .data_bus_req(bus.data_bus_req), .data_dev_oe(bus.data_dev_oe),
        .board_cache_idle(bus.board_cache_idle));
    // ********
    // Expectations and transfers
    // ********
    always #20 CLK_I = ~CLK_I;
    // A hang ends the run well past the few hundred cycles needed
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end
    function automatic logic [3:0] exp_cmd(input logic [2:0] k, input logic s);
        if (k == csb_pkg::REQ_MISS) return s ? csb_pkg::DCMD_MISS1 : csb_pkg::DCMD_MISS0;
        if (k == csb_pkg::REQ_VICTIM) return csb_pkg::DCMD_VICTIM;
        return k[0] ? csb_pkg::DCMD_MISS0 : csb_pkg::DCMD_WRBLK; // Odd kinds read
    endfunction : exp_cmd
    function automatic logic [3:0] exp_mask(input logic [2:0] k, input logic [1:0] l);
        if (k < csb_pkg::REQ_BW_READ || (k == csb_pkg::REQ_BW_WRITE && !l[1])) return REQ_MASK_I;
        return l == 2'h0 ? REQ_MASK_I : l == 2'h1 ? {REQ_LOW_ADDR_I[3:2], 2'h0} :
            l == 2'h2 ? {REQ_LOW_ADDR_I[3:1], 1'b0} : REQ_LOW_ADDR_I;
    endfunction : exp_mask
    task automatic dev_cmd(input logic [2:0] k, input logic [1:0] l, input logic s);
        logic [35:0] a;
        logic [3:0]  c;
        a = 36'({$random(seed), $random(seed)});
        a[35] = (k >= csb_pkg::REQ_NC_READ);
        c = (k == csb_pkg::REQ_BW_READ && l == 2'h1) ? 4'hC
            : (k >= csb_pkg::REQ_BW_READ && l == 2'h2) ? 4'hE : 4'hF;
        @(posedge CLK_I);
        {REQ_VALID_I, REQ_KIND_I, REQ_LEN_I, REQ_SLOT_I, REQ_ADDR_I} <= {1'b1, k, l, s, a};
        {REQ_LOW_ADDR_I, REQ_MASK_I, REQ_DATA_I} <= 136'({5{$random(seed)}});
        w = 0;
        @(posedge CLK_I);
        while (REQ_READY_O !== 1'b1 && w++ < 20) @(posedge CLK_I);
        REQ_VALID_I <= 1'b0;
        while (DEV_CMD_VALID_O !== 1'b1 && w++ < 30) @(posedge CLK_I);
        `CHK(DEV_CMD_O, exp_cmd(k, s))
        `CHK(DEV_ADDR_O, k >= csb_pkg::REQ_BW_READ ? {1'b1, l, a[32:0]} : a)
        if (k >= csb_pkg::REQ_NC_READ)
            `CHK(bus.lane_valid_mask & c, exp_mask(k, l) & c)
        if (k == csb_pkg::REQ_MISS) begin
            slot_a[s] = a;
            `CHK(s ? MISS_SLOT1_O : MISS_SLOT0_O, a)
        end
    endtask : dev_cmd
    task automatic probe(input logic [3:0] pc, input logic hit);
        @(posedge CLK_I);
        {PROBE_REQ_I, PROBE_CMD_I, PROBE_HIT_DIRTY_I} <= {1'b1, pc, hit};
        PROBE_ADDR_I <= 36'({$random(seed), $random(seed)});
        w = 0;
        @(posedge CLK_I);
        while (PROBE_BUSY_O !== 1'b0 && w++ < 20) @(posedge CLK_I);
        PROBE_REQ_I <= 1'b0;
        while (PROBE_VALID_O !== 1'b1 && w++ < 30) @(posedge CLK_I);
        `CHK(PROBE_CMD_O, pc)
        `CHK(PROBE_ADDR_O, PROBE_ADDR_I)
        @(posedge CLK_I);
        `CHK(PROBE_RESP_O, (hit && pc != csb_pkg::SCMD_INVAL) ? 2'h3 : 2'h1)
    endtask : probe
    task automatic fill(input logic s, input logic d, input logic f);
        @(posedge CLK_I);
        {FILL_REQ_I, FILL_SLOT_I, FILL_DIRTY_I, FILL_FAULT_I} <= {1'b1, s, d, f};
        FILL_DATA_I <= {4{$random(seed)}};
        w = 0;
        t = 0;
        n = 0;
        @(posedge CLK_I);
        while (FILL_BUSY_O !== 1'b0 && w++ < 20) @(posedge CLK_I);
        FILL_REQ_I <= 1'b0;
        CE_I       <= !(s && d);  // Freeze one edge while the cache idles
        // Fixed window covers the fill steps, a repeated write and a freeze
        repeat (12) begin
            @(posedge CLK_I);
            CE_I <= 1'b1;
            t += int'(MACHINE_CHECK_TRAP_O === 1'b1);
            if (BC_WRITE_O === 1'b1) begin
                n++;
                `CHK(BC_INDEX_O, slot_a[s])
                `CHK(BC_FILL_DIRTY_O, d)
                `CHK(BC_WDATA_O, FILL_DATA_I)
            end
        end
        `CHK(n, 1 + int'(d))
        `CHK(t, int'(f))
    endtask : fill
    task automatic conclude();
        if (miscompares == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    // Every kind with every length, then probes and fills
    initial begin
        {CLK_I, RST_I, CE_I} = 3'b011;
        {REQ_VALID_I, REQ_SLOT_I, PROBE_HIT_DIRTY_I, PROBE_REQ_I, FILL_REQ_I, FILL_SLOT_I,
         FILL_DIRTY_I, FILL_FAULT_I, REQ_KIND_I, REQ_LEN_I, REQ_LOW_ADDR_I, REQ_MASK_I,
         PROBE_CMD_I, REQ_ADDR_I, PROBE_ADDR_I, REQ_DATA_I, FILL_DATA_I} = '0;
        repeat (10) @(posedge CLK_I);
        RST_I <= 1'b0;
        for (i = 0; i < 28; i++) dev_cmd(3'(i % 7), 2'(i / 7), i[3]);
        dev_cmd(csb_pkg::REQ_MISS, 2'h0, 1'b0);
        dev_cmd(csb_pkg::REQ_MISS, 2'h0, 1'b1);
        for (i = 0; i < 6; i++) probe(i % 3 == 0 ? 4'h1 : i % 3 == 1 ? 4'h2 : 4'h4, i > 2);
        for (i = 0; i < 8; i++) fill(i[0], i[1], 1'($random(seed)));
        conclude();
    end
endmodule : cpu_system_bus_interface_tb
